// ---- inc/acor_regs.vh ----
// Register map, field positions and fixed values of the compensation override block.
// Assumes a 7-bit register address and 16-bit register data on the serial port.
`ifndef ACOR_REGS_VH
`define ACOR_REGS_VH

`define ACOR_ADDR_W 7
`define ACOR_DATA_W 16
`define ACOR_FRAME_BITS 5'h18
`define ACOR_HDR_BITS 5'h08
`define ACOR_FIRST_OUT 5'h09

`define ACOR_ADDR_COMP1 7'h04
`define ACOR_ADDR_COMP2 7'h05
`define ACOR_COMP1_RST 16'h0000
`define ACOR_COMP2_RST 16'h0110

`define ACOR_AUTO_EN_BIT 7
`define ACOR_MANUAL_BIT 15
`define ACOR_ZERO_MSB 14
`define ACOR_ZERO_LSB 12
`define ACOR_POLE_MSB 11
`define ACOR_POLE_LSB 9
`define ACOR_TCON_MSB 8
`define ACOR_TCON_LSB 7
`define ACOR_CAP_MSB 6
`define ACOR_CAP_LSB 3
`define ACOR_FBCAP_MSB 2
`define ACOR_FBCAP_LSB 0

`define ACOR_SAFE_TCON 2'h2
`define ACOR_SAFE_POLE 3'h0
`define ACOR_SAFE_ZERO 3'h0
`define ACOR_SAFE_CAP_HI 3'h7
`define ACOR_SAFE_CAP_LO 1'h1
`define ACOR_SAFE_FBCAP 3'h5

`define ACOR_MODE_SAFE 2'h0
`define ACOR_MODE_AUTO 2'h1
`define ACOR_MODE_MANUAL 2'h2

`endif

// ---- rtl/acor_comp_sel.v ----
// Mode decode and compensation source selection for the force amplifier.
// Assumes both compensation registers and the applied settings are held by the caller.
`timescale 1ns/1ns
`default_nettype none
`include "acor_regs.vh"

module acor_comp_sel (
    input wire [15:0] comp1,
    input wire [15:0] comp2,
    input wire [14:0] auto_settings,
    input wire [14:0] applied,
    output reg [1:0] mode,
    output reg [14:0] nxt_applied,
    output reg [15:0] comp2_readback
);

    wire [14:0] safe_settings;

    assign safe_settings = {`ACOR_SAFE_ZERO, `ACOR_SAFE_POLE, `ACOR_SAFE_TCON,
                            `ACOR_SAFE_CAP_HI, `ACOR_SAFE_CAP_LO, `ACOR_SAFE_FBCAP};

    always @* begin
        // The manual bit outranks the automatic enable of the first register.
        if (comp2[`ACOR_MANUAL_BIT]) begin
            mode = `ACOR_MODE_MANUAL;
        end else if (comp1[`ACOR_AUTO_EN_BIT]) begin
            mode = `ACOR_MODE_AUTO;
        end else begin
            mode = `ACOR_MODE_SAFE;
        end
    end

    always @* begin
        case (mode)
            `ACOR_MODE_MANUAL: nxt_applied = comp2[14:0];
            `ACOR_MODE_AUTO: nxt_applied = auto_settings;
            `ACOR_MODE_SAFE: nxt_applied = safe_settings;
            default: nxt_applied = safe_settings;
        endcase
    end

    always @* begin
        case (mode)
            `ACOR_MODE_MANUAL: comp2_readback = {comp2[15], applied};
            `ACOR_MODE_AUTO: comp2_readback = {comp2[15], applied};
            `ACOR_MODE_SAFE: comp2_readback = comp2;
            default: comp2_readback = comp2;
        endcase
    end

endmodule
`default_nettype wire

// ---- rtl/acor_top.v ----
// Compensation override register bank with its serial register port.
// Assumes sclk, sync_n and sdi are synchronous to clk and sclk runs at most clk/4.
`timescale 1ns/1ns
`default_nettype none
`include "acor_regs.vh"

module acor_top (
    input wire clk,
    input wire rstn,
    input wire ce,
    input wire sclk,
    input wire sync_n,
    input wire sdi,
    output wire sdo,
    output wire sdo_oe_n,
    input wire [14:0] auto_settings,
    output wire [1:0] comp_mode,
    output wire [2:0] zero_resistor_select,
    output wire [2:0] pole_resistor_select,
    output wire [1:0] transconductance_select,
    output wire [3:0] compensation_capacitor_select,
    output wire [2:0] feedback_capacitor_select
);

    localparam ST_IDLE = 1'b0;
    localparam ST_SHIFT = 1'b1;

    reg state_ff;
    reg nxt_state;
    reg sclk_ff;
    reg [4:0] cnt_ff;
    reg [4:0] nxt_cnt;
    reg [23:0] shin_ff;
    reg [23:0] nxt_shin;
    reg [15:0] shout_ff;
    reg [15:0] nxt_shout;
    reg rd_ff;
    reg nxt_rd;
    reg [15:0] comp1_ff;
    reg [15:0] nxt_comp1;
    reg [15:0] comp2_ff;
    reg [15:0] nxt_comp2;
    reg [14:0] applied_ff;
    reg [1:0] mode_ff;
    reg [15:0] rdata;

    wire sclk_rise;
    wire sclk_fall;
    wire [1:0] mode;
    wire [14:0] nxt_applied;
    wire [15:0] comp2_readback;
    wire [23:0] shin_next;
    wire [6:0] hdr_addr;
    wire hdr_read;

    assign sclk_rise = sclk & ~sclk_ff;
    assign sclk_fall = ~sclk & sclk_ff;
    assign shin_next = {shin_ff[22:0], sdi};
    // Header layout: read flag, then a 7-bit address, most significant bit first.
    assign hdr_read = shin_next[7];
    assign hdr_addr = shin_next[6:0];

    acor_comp_sel u_sel (
        .comp1(comp1_ff),
        .comp2(comp2_ff),
        .auto_settings(auto_settings),
        .applied(applied_ff),
        .mode(mode),
        .nxt_applied(nxt_applied),
        .comp2_readback(comp2_readback)
    );

    // Unmapped addresses read as zero and swallow writes.
    always @* begin
        case (hdr_addr)
            `ACOR_ADDR_COMP1: rdata = comp1_ff;
            `ACOR_ADDR_COMP2: rdata = comp2_readback;
            default: rdata = 16'h0000;
        endcase
    end

    always @* begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_shin = shin_ff;
        nxt_shout = shout_ff;
        nxt_rd = rd_ff;
        nxt_comp1 = comp1_ff;
        nxt_comp2 = comp2_ff;
        case (state_ff)
            ST_IDLE: begin
                nxt_cnt = 5'h00;
                nxt_rd = 1'b0;
                if (!sync_n) begin
                    nxt_state = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                // A frame cut short by sync_n leaves every register untouched.
                if (sync_n) begin
                    nxt_state = ST_IDLE;
                    nxt_cnt = 5'h00;
                    nxt_rd = 1'b0;
                end else if (sclk_rise && cnt_ff != `ACOR_FRAME_BITS) begin
                    nxt_shin = shin_next;
                    nxt_cnt = cnt_ff + 5'h01;
                    if (cnt_ff == `ACOR_HDR_BITS - 5'h01 && hdr_read) begin
                        nxt_rd = 1'b1;
                        nxt_shout = rdata;
                    end
                    if (cnt_ff == `ACOR_FRAME_BITS - 5'h01 && !shin_next[23]) begin
                        case (shin_next[22:16])
                            `ACOR_ADDR_COMP1: nxt_comp1 = shin_next[15:0];
                            // Stored in every mode; only manual mode applies it to the select outputs.
                            `ACOR_ADDR_COMP2: nxt_comp2 = shin_next[15:0];
                            default: nxt_comp2 = comp2_ff;
                        endcase
                    end
                end else if (sclk_fall && rd_ff && cnt_ff >= `ACOR_FIRST_OUT) begin
                    nxt_shout = {shout_ff[14:0], 1'b0};
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= ST_IDLE;
            sclk_ff <= 1'b0;
            cnt_ff <= 5'h00;
            shin_ff <= 24'h000000;
            shout_ff <= 16'h0000;
            rd_ff <= 1'b0;
        end else if (ce) begin
            state_ff <= nxt_state;
            sclk_ff <= sclk;
            cnt_ff <= nxt_cnt;
            shin_ff <= nxt_shin;
            shout_ff <= nxt_shout;
            rd_ff <= nxt_rd;
        end
    end

    // Reset values leave both mode bits low, so the amplifier starts in safe mode.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            comp1_ff <= `ACOR_COMP1_RST;
            comp2_ff <= `ACOR_COMP2_RST;
            applied_ff <= {`ACOR_SAFE_ZERO, `ACOR_SAFE_POLE, `ACOR_SAFE_TCON,
                           `ACOR_SAFE_CAP_HI, `ACOR_SAFE_CAP_LO, `ACOR_SAFE_FBCAP};
            mode_ff <= `ACOR_MODE_SAFE;
        end else if (ce) begin
            comp1_ff <= nxt_comp1;
            comp2_ff <= nxt_comp2;
            applied_ff <= nxt_applied;
            mode_ff <= mode;
        end
    end

    assign sdo = shout_ff[15];
    assign sdo_oe_n = ~rd_ff;
    assign comp_mode = mode_ff;
    // The zero resistor code is passed straight to the resistor ladder decoder.
    assign zero_resistor_select = applied_ff[`ACOR_ZERO_MSB:`ACOR_ZERO_LSB];
    assign pole_resistor_select = applied_ff[`ACOR_POLE_MSB:`ACOR_POLE_LSB];
    assign transconductance_select = applied_ff[`ACOR_TCON_MSB:`ACOR_TCON_LSB];
    assign compensation_capacitor_select = applied_ff[`ACOR_CAP_MSB:`ACOR_CAP_LSB];
    assign feedback_capacitor_select = applied_ff[`ACOR_FBCAP_MSB:`ACOR_FBCAP_LSB];

endmodule
`default_nettype wire

// ---- verification/acor_host.sv ----
// Host model of the serial register port.
// Assumes one caller at a time and h of at least 3 clk.
`timescale 1ns/1ns
`default_nettype none
module acor_host (
    input wire logic clk,
    input wire logic sdo,
    input wire logic sdo_oe_n,
    output var logic sclk,
    output var logic sync_n,
    output var logic sdi
);
    initial begin
        sclk = 1'b0;
        sync_n = 1'b1;
        sdi = 1'b0;
    end
    // An undriven sdo reads as unknown, so a missing enable cannot pass a compare.
    task automatic frame(input logic rd, input logic [6:0] a, input logic [15:0] d,
        input int h, output logic [15:0] q);
        logic [23:0] w;
        w = {rd, a, d};
        q = 16'h0000;
        @(posedge clk) sync_n <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            sdi <= w[i];
            repeat (h) @(posedge clk);
            sclk <= 1'b1;
            if (i < 16) q[i] = sdo_oe_n ? 1'bx : sdo;
            repeat (h) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (h) @(posedge clk);
        sync_n <= 1'b1;
        sdi <= ~sdi;
        repeat (3) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ---- verification/acor_top_asserts.sv ----
// Port checks of the compensation override block.
// Assumes one clock and rstn asynchronous, active low.
`timescale 1ns/1ns
`default_nettype none
module acor_top_asserts (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic sync_n,
    input wire logic sdo_oe_n,
    input wire logic [14:0] auto_settings,
    input wire logic [1:0] comp_mode,
    input wire logic [2:0] zero_resistor_select,
    input wire logic [2:0] pole_resistor_select,
    input wire logic [1:0] transconductance_select,
    input wire logic [3:0] compensation_capacitor_select,
    input wire logic [2:0] feedback_capacitor_select
);
    wire [14:0] app = {zero_resistor_select, pole_resistor_select, transconductance_select,
        compensation_capacitor_select, feedback_capacitor_select};
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_quiet;
        (ce && sync_n) [*3];
    endsequence
    a_reset_to_safe: assert property ($rose(rstn) |-> comp_mode == 2'h0)
        else $error("mode not safe");
    a_safe_fixed_values: assert property (comp_mode == 2'h0 |-> app == 15'h017d)
        else $error("safe settings wrong");
    a_auto_tracks_engine: assert property (
        comp_mode == 2'h1 && $past(ce) |-> app == $past(auto_settings))
        else $error("engine not applied");
    a_mode_after_frame: assert property ($changed(comp_mode) |-> !$past(sync_n))
        else $error("mode moved outside frame");
    a_manual_holds: assert property (
        comp_mode == 2'h2 && $past(comp_mode) == 2'h2 && $past(sync_n) |-> $stable(app))
        else $error("manual settings moved");
    a_mode_code_legal: assert property (comp_mode != 2'h3)
        else $error("bad mode code");
    a_oe_released: assert property (s_quiet |-> sdo_oe_n)
        else $error("sdo driven when idle");
    a_oe_after_header: assert property ($fell(sdo_oe_n) |-> !sync_n && !$past(sync_n, 8))
        else $error("sdo driven early");
endmodule
bind acor_top acor_top_asserts u_chk (.clk, .rstn, .ce, .sync_n, .sdo_oe_n, .auto_settings,
    .comp_mode, .zero_resistor_select, .pole_resistor_select, .transconductance_select,
    .compensation_capacitor_select, .feedback_capacitor_select);
`default_nettype wire

// ---- verification/tb_top.sv ----
// Self-checking bench of the compensation override block.
// Assumes the host model owns the serial pins.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic clk, rstn, ce, sclk, sync_n, sdi, sdo, sdo_oe_n;
    logic [14:0] auto_settings;
    wire [16:0] outs;
    logic [15:0] q0;
    int c1, c2, errors, samples_checked;
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    acor_host host (.clk(clk), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .sclk(sclk), .sync_n(sync_n),
        .sdi(sdi));
    acor_top dut (.clk(clk), .rstn(rstn), .ce(ce), .sclk(sclk), .sync_n(sync_n), .sdi(sdi),
        .sdo(sdo), .sdo_oe_n(sdo_oe_n), .auto_settings(auto_settings),
        .comp_mode(outs[16:15]), .zero_resistor_select(outs[14:12]),
        .pole_resistor_select(outs[11:9]), .transconductance_select(outs[8:7]),
        .compensation_capacitor_select(outs[6:3]), .feedback_capacitor_select(outs[2:0]));
    function automatic logic [1:0] mode();
        return c2[15] ? 2'h2 : c1[7] ? 2'h1 : 2'h0;
    endfunction
    function automatic logic [14:0] app();
        return mode() == 2'h2 ? c2[14:0] : mode() == 2'h1 ? auto_settings : 15'h017d;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic access(input logic rd, input logic [6:0] a, input logic [15:0] d);
        logic [15:0] q;
        host.frame(rd, a, d, 3 + ($urandom % 3), q);
        if (!rd && a == 7'h04) c1 = d;
        if (!rd && a == 7'h05) c2 = d;
        @(negedge clk);
        if (rd) chk(q, a != 7'h05 ? 16'h0 : mode() == 2'h0 ? c2[15:0] : {c2[15], app()});
        chk(outs, {mode(), app()});
    endtask
    task automatic print_verdict();
        if (errors == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        errors++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'hdd14));
        rstn <= 1'b0;
        ce <= 1'b1;
        auto_settings <= 15'h0000;
        c2 = 16'h0110;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        chk(outs, {2'h0, 15'h017d});
        access(1'b1, 7'h05, 16'h0);
        access(1'b0, 7'h05, {1'b0, 15'($urandom)});
        access(1'b1, 7'h05, 16'h0);
        access(1'b0, 7'h04, 16'h0080);
        for (int k = 0; k < 8; k++) begin
            access(1'b0, 7'h05, {1'b1, k[2:0], 12'($urandom)});
            @(posedge clk) auto_settings <= 15'($urandom);
            access(1'b1, 7'h05, 16'h0);
            access(1'b0, 7'h05, {1'b0, 15'($urandom)});
            access(1'b1, 7'h05, 16'h0);
            access(1'b0, 7'h33, 16'hffff);
            access(1'b1, 7'h33, 16'h0);
        end
        // A frozen block must ignore a whole frame, so manual mode is not entered.
        @(posedge clk) ce <= 1'b0;
        host.frame(1'b0, 7'h05, 16'hffff, 3, q0);
        @(posedge clk) ce <= 1'b1;
        @(negedge clk);
        chk(outs, {mode(), app()});
        access(1'b1, 7'h05, 16'h0);
        access(1'b0, 7'h04, 16'h0);
        access(1'b1, 7'h05, 16'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
